// *** logic/mfpc_consts.vh ***
// Constants of the two-pin role and configuration block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef MFPC_CONSTS_VH
`define MFPC_CONSTS_VH

// =====================================================================
// Register indices (byte address is four times the index)
`define MFPC_IDX_PIN_A 8'h74
`define MFPC_IDX_PIN_B 8'h75
`define MFPC_IDX_STATUS 8'h78
`define MFPC_IDX_MASK 8'h79
`define MFPC_IDX_STATE 8'h7a

// =====================================================================
// Configuration field positions
`define MFPC_ROLE_HI 13
`define MFPC_ROLE_LO 8
`define MFPC_DIR 7
`define MFPC_DRIVE 6
`define MFPC_POL 5
`define MFPC_LVL 4
`define MFPC_PD 3
`define MFPC_PU 2
`define MFPC_TRIG 1
`define MFPC_DB 0
`define MFPC_CFG_W 14

// =====================================================================
// Role codes
`define MFPC_ROLE_OUT 6'h00
`define MFPC_ROLE_IRQ 6'h02
`define MFPC_ROLE_IN 6'h03
`define MFPC_ROLE_MIC6 6'h06
`define MFPC_ROLE_MIC7 6'h07
`define MFPC_ROLE_LOCK 6'h08
`define MFPC_ROLE_FCLK 6'h09

// =====================================================================
// Reset values
`define MFPC_PIN_A_RST 14'h00a8
`define MFPC_PIN_B_RST 14'h00a8
`define MFPC_MASK_RST 2'h0

// =====================================================================
// Timing
`define MFPC_DEBOUNCE_CYCLES 16

`endif

// *** logic/mfpc_pin_drive.v ***
// Output side of one multi-function pin: role mux and drive type.
// Assumes the sources it selects are already on hclk.
`timescale 1ns/1ps
`include "mfpc_consts.vh"

module mfpc_pin_drive #(
  parameter PIN_B = 0
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // Configuration
  input wire [`MFPC_CFG_W-1:0] cfg,
  // Sources
  input wire irq_level,
  input wire mic_clk,
  input wire fll_lock,
  input wire fll_clk,
  // Pad
  output reg pad_out,
  output reg pad_oe
);

  wire [5:0] role = cfg[`MFPC_ROLE_HI:`MFPC_ROLE_LO];
  reg drives;
  reg level;
  reg next_out;
  reg next_oe;

  // Direction bit gates every output role; reserved codes never drive
  always @* begin
    drives = 1'b0;
    level = 1'b0;
    case (role)
      `MFPC_ROLE_OUT: begin
        drives = 1'b1;
        level = cfg[`MFPC_LVL];
      end
      `MFPC_ROLE_IRQ: begin
        drives = 1'b1;
        level = irq_level;
      end
      `MFPC_ROLE_MIC6: begin
        drives = (PIN_B == 0);
        level = mic_clk;
      end
      `MFPC_ROLE_MIC7: begin
        drives = (PIN_B != 0);
        level = mic_clk;
      end
      `MFPC_ROLE_LOCK: begin
        drives = 1'b1;
        level = fll_lock;
      end
      `MFPC_ROLE_FCLK: begin
        drives = 1'b1;
        level = fll_clk;
      end
      default: begin
        drives = 1'b0;
        level = 1'b0;
      end
    endcase
    drives = drives & ~cfg[`MFPC_DIR];
    // Open drain only pulls low; a high level releases the pin
    if (cfg[`MFPC_DRIVE]) begin
      next_out = 1'b0;
      next_oe = drives & ~level;
    end else begin
      next_out = level;
      next_oe = drives;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
    end else if (ce) begin
      pad_out <= next_out;
      pad_oe <= next_oe;
    end
  end

endmodule

// *** logic/mfpc_sync.v ***
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent level; no bus coherency is kept.
`timescale 1ns/1ps

module mfpc_sync #(
  parameter W = 2
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // Data
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  reg [W-1:0] meta;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else if (ce) begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// *** logic/mfpc_top.v ***
// Two multi-function pins with per-pin role, drive, pulls, input
// interpretation, debounce and interrupt detection, on AHB-Lite.
// Assumes pads and loop signals are asynchronous to hclk; the channel
// clock for the microphone comes from logic on hclk.
//
// Operation
// - A six-bit role field at bits 13:8 picks plain output (00h), interrupt output (02h) or plain input (03h), with 01h, 04h and 05h reserved.
// - On the first pin code 06h drives the microphone channel clock out and 07h is reserved.
// - On the second pin code 06h takes the pin as microphone data and 07h drives the channel clock out.
// - On either pin 08h outputs loop lock, 09h outputs the loop clock, and 0Ah to 3Fh are reserved.
// - Bit 7 is direction (0 out, 1 in, input after reset) and bit 6 picks push-pull (0) or open drain (1).
// - Bit 5 sets input polarity, 0 active low and 1 active high, reset value 1.
// - In plain output role the pin drives the level held in bit 4.
// - Bit 3 enables the weak pull-down and is set after reset on both pins.
// - Bit 2 enables the weak pull-up and is clear after reset.
// - Bit 1 picks level (0) or edge (1) interrupt detection on an input pin, bit 0 turns debounce on.
`timescale 1ns/1ps
`include "mfpc_consts.vh"

module mfpc_top #(
  parameter ADDR_W = 10,
  parameter DEBOUNCE_CYCLES = `MFPC_DEBOUNCE_CYCLES
) (
  // Clock, reset and enable
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // AHB-Lite slave
  input wire hsel,
  input wire [ADDR_W-1:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Pads, bit 0 first pin, bit 1 second pin
  input wire [1:0] pad_in,
  output wire [1:0] pad_out,
  output wire [1:0] pad_oe,
  output wire [1:0] pullup_on,
  output wire [1:0] pulldown_on,
  // Microphone and loop
  input wire mic_channel_clock,
  output reg mic_serial_input,
  input wire freq_locked_loop_lock,
  input wire freq_locked_loop_clock,
  // Interrupt
  output wire irq
);

  localparam CNT_W = 16;
  localparam [31:0] DB_LAST_FULL = DEBOUNCE_CYCLES - 1;
  localparam [CNT_W-1:0] DB_LAST = DB_LAST_FULL[CNT_W-1:0];

  // =====================================================================
  // Configuration and interrupt registers
  reg [`MFPC_CFG_W-1:0] pin_a_config;
  reg [`MFPC_CFG_W-1:0] pin_b_config;
  reg [1:0] int_status;
  reg [1:0] int_mask;

  wire [`MFPC_CFG_W-1:0] cfg [0:1];
  assign cfg[0] = pin_a_config;
  assign cfg[1] = pin_b_config;

  wire [5:0] pin_a_role_select = pin_a_config[`MFPC_ROLE_HI:`MFPC_ROLE_LO];
  wire [5:0] pin_b_role_select = pin_b_config[`MFPC_ROLE_HI:`MFPC_ROLE_LO];

  // =====================================================================
  // Bus slave: zero wait states while enabled
  wire [7:0] addr_idx = haddr[9:2];
  wire accept = ce & hsel & hready & htrans[1];
  reg wr_pend;
  reg [7:0] wr_idx;
  reg [31:0] next_rdata;

  assign hreadyout = ce;
  assign hresp = 1'b0;

  wire hit_a = (addr_idx == `MFPC_IDX_PIN_A);
  wire hit_b = (addr_idx == `MFPC_IDX_PIN_B);
  wire hit_status = (addr_idx == `MFPC_IDX_STATUS);
  wire hit_mask = (addr_idx == `MFPC_IDX_MASK);
  wire hit_state = (addr_idx == `MFPC_IDX_STATE);

  wire rd_status = accept & ~hwrite & hit_status;
  wire wr_a = ce & wr_pend & (wr_idx == `MFPC_IDX_PIN_A);
  wire wr_b = ce & wr_pend & (wr_idx == `MFPC_IDX_PIN_B);
  wire wr_mask = ce & wr_pend & (wr_idx == `MFPC_IDX_MASK);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
    end else if (ce) begin
      wr_pend <= accept & hwrite;
      wr_idx <= addr_idx;
    end
  end

  // =====================================================================
  // Pad synchronisers
  wire [1:0] pad_sync;
  wire [1:0] loop_sync;

  mfpc_sync #(
    .W(2)
  ) u_pad_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .async_in(pad_in),
    .sync_out(pad_sync)
  );

  // Loop clock sampled at hclk: only slow loop clocks survive intact
  mfpc_sync #(
    .W(2)
  ) u_loop_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .async_in({freq_locked_loop_clock, freq_locked_loop_lock}),
    .sync_out(loop_sync)
  );

  // =====================================================================
  // Per-pin input path: debounce, polarity, detection
  wire [1:0] filtered;
  wire [1:0] active;
  wire [1:0] event_hit;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pin
      reg stable;
      reg active_d;
      reg [CNT_W-1:0] db_cnt;
      wire db_on = cfg[g][`MFPC_DB];
      wire is_input = (cfg[g][`MFPC_ROLE_HI:`MFPC_ROLE_LO] == `MFPC_ROLE_IN);

      // A change must hold for the full count before it is believed
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          stable <= 1'b0;
          db_cnt <= {CNT_W{1'b0}};
        end else if (ce) begin
          if (!db_on) begin
            stable <= pad_sync[g];
            db_cnt <= {CNT_W{1'b0}};
          end else if (pad_sync[g] == stable) begin
            db_cnt <= {CNT_W{1'b0}};
          end else if (db_cnt == DB_LAST) begin
            stable <= pad_sync[g];
            db_cnt <= {CNT_W{1'b0}};
          end else begin
            db_cnt <= db_cnt + 1'b1;
          end
        end
      end

      assign filtered[g] = stable;
      assign active[g] = cfg[g][`MFPC_POL] ? stable : ~stable;

      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          active_d <= 1'b0;
        end else if (ce) begin
          active_d <= active[g];
        end
      end

      // Level mode keeps re-setting the flag while the input is active
      assign event_hit[g] = is_input &
        (cfg[g][`MFPC_TRIG] ? (active[g] & ~active_d) : active[g]);

      assign pullup_on[g] = cfg[g][`MFPC_PU];
      assign pulldown_on[g] = cfg[g][`MFPC_PD];
    end
  endgenerate

  // =====================================================================
  // Register writes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_a_config <= `MFPC_PIN_A_RST;
      pin_b_config <= `MFPC_PIN_B_RST;
      int_mask <= `MFPC_MASK_RST;
    end else begin
      if (wr_a) begin
        pin_a_config <= hwdata[`MFPC_CFG_W-1:0];
      end
      if (wr_b) begin
        pin_b_config <= hwdata[`MFPC_CFG_W-1:0];
      end
      if (wr_mask) begin
        int_mask <= hwdata[1:0];
      end
    end
  end

  // =====================================================================
  // Sticky status: a read clears, a new event in that cycle survives
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_status <= 2'h0;
    end else if (ce) begin
      int_status <= (rd_status ? 2'h0 : int_status) | event_hit;
    end
  end

  assign irq = |(int_status & int_mask);

  // =====================================================================
  // Read data, captured in the address phase
  always @* begin
    next_rdata = 32'h0000_0000;
    if (hit_a) begin
      next_rdata = {18'h00000, pin_a_config};
    end else if (hit_b) begin
      next_rdata = {18'h00000, pin_b_config};
    end else if (hit_status) begin
      next_rdata = {30'h0000_0000, int_status};
    end else if (hit_mask) begin
      next_rdata = {30'h0000_0000, int_mask};
    end else if (hit_state) begin
      next_rdata = {28'h000_0000, pad_sync, active};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (accept & ~hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // =====================================================================
  // Microphone data: taken from the second pin only in role 06h
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mic_serial_input <= 1'b0;
    end else if (ce) begin
      mic_serial_input <= (pin_b_role_select == `MFPC_ROLE_MIC6) &
                          pin_b_config[`MFPC_DIR] & filtered[1];
    end
  end

  // =====================================================================
  // Output drivers
  mfpc_pin_drive #(
    .PIN_B(0)
  ) u_drive_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .cfg(pin_a_config),
    .irq_level(irq),
    .mic_clk(mic_channel_clock),
    .fll_lock(loop_sync[0]),
    .fll_clk(loop_sync[1]),
    .pad_out(pad_out[0]),
    .pad_oe(pad_oe[0])
  );

  mfpc_pin_drive #(
    .PIN_B(1)
  ) u_drive_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .cfg(pin_b_config),
    .irq_level(irq),
    .mic_clk(mic_channel_clock),
    .fll_lock(loop_sync[0]),
    .fll_clk(loop_sync[1]),
    .pad_out(pad_out[1]),
    .pad_oe(pad_oe[1])
  );

endmodule

// *** testbench/mfpc_board.sv ***
// Board around the two pads: outside drivers, pull resistors, loop signals.
// Assumes the bench sets ext_on and ext_lvl; a floating pad wanders.
`timescale 1ns/1ps
module mfpc_board (
  // Block side
  input wire [1:0] pad_out,
  input wire [1:0] pad_oe,
  input wire [1:0] pullup_on,
  input wire [1:0] pulldown_on,
  output logic [1:0] pad_in,
  // Bench side
  input wire [1:0] ext_on,
  input wire [1:0] ext_lvl,
  input wire lock_set,
  output logic lock,
  output logic fclk
);
  logic wander = 1'b0;
  // Loop clock runs free and unrelated to hclk
  initial fclk = 1'b0;
  always #35 wander = ~wander;
  always #90 fclk = ~fclk;
  always @* begin
    lock = lock_set;
    for (int i = 0; i < 2; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_on[i]) pad_in[i] = ext_lvl[i];
      else if (pullup_on[i]) pad_in[i] = 1'b1;
      else if (pulldown_on[i]) pad_in[i] = 1'b0;
      else pad_in[i] = wander;
    end
  end
endmodule

// *** testbench/mfpc_monitor.sv ***
// Checker for mfpc_top: pulls and pad drive against shadows of both configs.
// Assumes only bus writes change the configs; bound after the module.
`timescale 1ns/1ps
`include "mfpc_consts.vh"
module mfpc_monitor (
  // Bus
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire hsel,
  input wire [9:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  // Pads
  input wire [1:0] pad_out,
  input wire [1:0] pad_oe,
  input wire [1:0] pullup_on,
  input wire [1:0] pulldown_on,
  input wire mic_serial_input
);
  // ==========
  // Config shadows
  reg [1:0] wr;
  reg [13:0] ca, cb, pa, pb;
  // Pads lag a config change by one edge, so pad checks wait for a quiet edge
  wire q = ca == pa && cb == pb;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr <= 2'h0;
      ca <= `MFPC_PIN_A_RST;
      cb <= `MFPC_PIN_B_RST;
      pa <= `MFPC_PIN_A_RST;
      pb <= `MFPC_PIN_B_RST;
    end else begin
      pa <= ca;
      pb <= cb;
      if (hready) begin
        wr[0] <= ce && hsel && htrans[1] && hwrite && haddr[9:2] == `MFPC_IDX_PIN_A;
        wr[1] <= ce && hsel && htrans[1] && hwrite && haddr[9:2] == `MFPC_IDX_PIN_B;
        if (wr[0]) ca <= hwdata[13:0];
        if (wr[1]) cb <= hwdata[13:0];
      end
    end
  end
  // ==========
  // Properties
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  pull_up_a: assert property (pullup_on == {cb[2], ca[2]})
    else $error("pull-up differs from config");
  pull_down_a: assert property (pulldown_on == {cb[3], ca[3]})
    else $error("pull-down differs from config");
  level_pin_a: assert property (q && ca[13:7] == 7'h0 && !ca[6] |-> pad_oe[0] && pad_out[0] == ca[4])
    else $error("first pin level wrong");
  level_pin_b_a: assert property (q && cb[13:7] == 7'h0 && !cb[6] |-> pad_oe[1] && pad_out[1] == cb[4])
    else $error("second pin level wrong");
  open_drain_a: assert property (q && ca[13:7] == 7'h0 && ca[6] |-> !pad_out[0] && pad_oe[0] == !ca[4])
    else $error("open drain wrong");
  input_dir_a: assert property (q |-> !(ca[7] && pad_oe[0]) && !(cb[7] && pad_oe[1]))
    else $error("input pin driven");
  reserved_role_a: assert property (q && (ca[13:8] == 6'h07 || ca[13:8] > 6'h09) |-> !pad_oe[0])
    else $error("reserved role drives");
  mic_off_a: assert property (q && cb[13:7] != 7'h0d |-> !mic_serial_input)
    else $error("mic data outside its role");
endmodule
bind mfpc_top mfpc_monitor mfpc_monitor_inst (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .pad_out(pad_out), .pad_oe(pad_oe), .pullup_on(pullup_on),
  .pulldown_on(pulldown_on), .mic_serial_input(mic_serial_input));

// *** testbench/multi_function_pin_control_test.sv ***
// Self-checking bench for mfpc_top over AHB-Lite with the board model.
// Assumes a zero-wait slave with ce tied high; short debounce count.
`timescale 1ns/1ps
`include "mfpc_consts.vh"
module multi_function_pin_control_test;
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, mic = 1'b0, lock_set = 1'b0;
  logic [9:0] haddr = 10'h000;
  logic [1:0] htrans = 2'h0, ext_on = 2'h0, ext_lvl = 2'h0;
  logic [31:0] hwdata = 32'h0, rd;
  wire hready, resp, mic_data, lock, fclk, irq;
  wire [31:0] hrdata;
  wire [1:0] pad_in, pad_out, pad_oe, pu, pd;
  int fails = 0, n_checks = 0;
  always #25 hclk = ~hclk;
  mfpc_top #(.DEBOUNCE_CYCLES(2)) mfpc_top_inst (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(resp), .hrdata(hrdata), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pullup_on(pu), .pulldown_on(pd), .mic_channel_clock(mic),
    .mic_serial_input(mic_data), .freq_locked_loop_lock(lock),
    .freq_locked_loop_clock(fclk), .irq(irq));
  mfpc_board mfpc_board_inst (
    .pad_out(pad_out), .pad_oe(pad_oe), .pullup_on(pu), .pulldown_on(pd),
    .pad_in(pad_in), .ext_on(ext_on), .ext_lvl(ext_lvl), .lock_set(lock_set),
    .lock(lock), .fclk(fclk));
  // ==========
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Called just after a rising edge; byte address is four times the index
  // A slave that never answers is caught by the watchdog, not here
  task automatic bus(input logic [7:0] idx, input logic w, input logic [31:0] d);
    haddr <= {idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic glitch(input logic [31:0] cfg, input logic [31:0] exp);
    ext_lvl <= 2'b01;
    bus(`MFPC_IDX_PIN_A, 1'b1, cfg);
    tick(8);
    bus(`MFPC_IDX_STATUS, 1'b0, 32'h0);
    ext_lvl <= 2'b00;
    @(posedge hclk);
    ext_lvl <= 2'b01;
    tick(8);
    bus(`MFPC_IDX_STATUS, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    bus(`MFPC_IDX_PIN_A, 1'b0, 32'h0);
    chk(rd, 32'h00a8);
    bus(`MFPC_IDX_PIN_B, 1'b0, 32'h0);
    chk(rd, 32'h00a8);
    chk({pu, pd, pad_oe}, 6'h0c);
    bus(8'h10, 1'b1, 32'hffff);
    bus(8'h10, 1'b0, 32'h0);
    chk(rd, 32'h0);
    chk(resp, 1'b0);
  endtask
  task automatic t_output;
    logic [15:0] cv [4] = '{16'h0010, 16'h0000, 16'h0044, 16'h005c};
    logic [3:0] ev [4] = '{4'hc, 4'h8, 4'ha, 4'h3};
    bus(`MFPC_IDX_PIN_A, 1'b1, 32'hffff);
    bus(`MFPC_IDX_PIN_A, 1'b0, 32'h0);
    chk(rd, 32'h3fff);
    for (int i = 0; i < 4; i++) begin
      bus(`MFPC_IDX_PIN_A, 1'b1, {16'h0, cv[i]});
      tick(3);
      chk({pad_oe[0], pad_out[0], pu[0], pd[0]}, ev[i]);
    end
  endtask
  task automatic t_roles;
    logic [5:0] code [12] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
      6'h06, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h3f};
    logic [11:0] drv_a = 12'b001101000101, drv_b = 12'b001110000101;
    logic [1:0] hi, lo;
    mic <= 1'b1;
    lock_set <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      bus(`MFPC_IDX_PIN_A, 1'b1, {18'h0, code[i], 8'h00});
      bus(`MFPC_IDX_PIN_B, 1'b1, {18'h0, code[i], 8'h00});
      tick(4);
      chk(pad_oe, {drv_b[i], drv_a[i]});
      if (code[i] == 6'h06 || code[i] == 6'h07 || code[i] == 6'h08) begin
        chk(pad_out & pad_oe, pad_oe);
      end
      // The loop clock is free running, so both levels must show on both pads
      if (code[i] == 6'h09) begin
        hi = 2'h0;
        lo = 2'h0;
        repeat (8) begin
          @(negedge hclk);
          hi = hi | pad_out;
          lo = lo | ~pad_out;
        end
        @(posedge hclk);
        chk({hi, lo}, 4'hf);
      end
    end
  endtask
  task automatic t_irq;
    bus(`MFPC_IDX_PIN_B, 1'b1, 32'h0200);
    bus(`MFPC_IDX_MASK, 1'b1, 32'h1);
    bus(`MFPC_IDX_PIN_A, 1'b1, 32'h03a0);
    ext_on <= 2'b01;
    ext_lvl <= 2'b01;
    tick(6);
    bus(`MFPC_IDX_STATUS, 1'b0, 32'h0);
    tick(4);
    chk({irq, pad_out[1], pad_oe[1]}, 3'h7);
    bus(`MFPC_IDX_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h1);
    ext_lvl <= 2'b00;
    tick(6);
    bus(`MFPC_IDX_STATUS, 1'b0, 32'h0);
    tick(2);
    chk({irq, pad_out[1]}, 2'h0);
  endtask
  task automatic t_edge;
    bus(`MFPC_IDX_PIN_A, 1'b1, 32'h0382);
    tick(6);
    bus(`MFPC_IDX_STATE, 1'b0, 32'h0);
    chk(rd[0], 1'b1);
    glitch(32'h0383, 32'h0);
    glitch(32'h0382, 32'h1);
    ext_lvl <= 2'b00;
    tick(6);
    bus(`MFPC_IDX_MASK, 1'b1, 32'h0);
    tick(1);
    chk(irq, 1'b0);
    bus(`MFPC_IDX_STATUS, 1'b0, 32'h0);
    bus(`MFPC_IDX_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_mic;
    bus(`MFPC_IDX_PIN_B, 1'b1, 32'h0680);
    ext_on <= 2'b10;
    ext_lvl <= 2'b10;
    tick(8);
    chk({mic_data, pad_oe[1]}, 2'h2);
    ext_lvl <= 2'b00;
    tick(8);
    chk(mic_data, 1'b0);
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    tick(2);
    hresetn <= 1'b1;
    tick(1);
    t_reset;
    t_output;
    t_roles;
    t_irq;
    t_edge;
    t_mic;
    give_verdict;
  end
  // Whole run needs well under 2000 cycles
  initial begin
    #200000;
    fails++;
    give_verdict;
  end
endmodule
